// ---- hdl/mhc_chan_regs.vh ----
// Register offsets, field positions and reset values of the channel control
`ifndef MHC_CHAN_REGS_VH
`define MHC_CHAN_REGS_VH
// Parameter areas (global at 0x00, channel at 0x40)
`define MHC_GLOBAL_BASE     8'h00
`define MHC_CHAN_BASE       8'h40
// Global area offsets
`define MHC_OFF_GLOBAL_RUN  8'h04
`define MHC_OFF_MODE        8'h10
`define MHC_OFF_COMMAND     8'h14
`define MHC_OFF_BD_LEN      8'h18
`define MHC_OFF_MAX_RX_LEN  8'h1c
`define MHC_OFF_IRQ_STATUS  8'h20
`define MHC_OFF_IRQ_MASK    8'h24
`define MHC_OFF_TX_DATA     8'h28
`define MHC_OFF_RX_DATA     8'h2c
// Channel area offsets (relative to channel base)
`define MHC_OFF_TX_STATE    8'h04
`define MHC_OFF_TX_PTR      8'h08
`define MHC_OFF_ZD_STATE    8'h0c
`define MHC_OFF_TX_COUNT    8'h0e
`define MHC_OFF_RX_STATE    8'h24
`define MHC_OFF_RX_PTR      8'h28
`define MHC_OFF_RX_COUNT    8'h2e
// Mode register fields
`define MHC_MODE_HDLC       0
`define MHC_MODE_IDLE_FLAG  1
`define MHC_MODE_ENT        2
`define MHC_MODE_POLL       3
`define MHC_MODE_SLOT_VALID 4
`define MHC_MODE_RUN        5
// Command register fields
`define MHC_CMD_TX_STOP     0
`define MHC_CMD_RX_STOP     1
// State word fields
`define MHC_ST_STOPPED      0
`define MHC_ST_FRAME        8
`define MHC_ST_BD_OPEN      9
`define MHC_ST_HALTED       11
`define MHC_ST_RUNNING      12
// Interrupt event bits
`define MHC_EV_TX_DONE      0
`define MHC_EV_RX_FULL      1
`define MHC_EV_TX_STOPPED   2
`define MHC_EV_RX_STOPPED   3
// Reset values and line patterns
`define MHC_RST_RX_STATE    32'h39000000
`define MHC_RST_TX_STATE    32'h38000000
`define MHC_FLAG_BYTE       8'h7e
`define MHC_IDLE_BYTE       8'hff
`endif

// ---- hdl/mhc_chan_ctrl.v ----
// Channel control: start, stop, pointers, counters and state words
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
`include "mhc_chan_regs.vh"

module mhc_chan_ctrl
(
  // Clock, reset and enable
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        ce_in,
  // Register port
  input  wire [7:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  // Serial link
  input  wire        link_clk_in,
  input  wire        rx_bit_in,
  output reg         tx_bit_out,
  // Interrupt
  output wire        irq_out
);

  //////////////////////////////////////////////////////////////////////////
  // Storage
  reg  [1:0]  lclk_sync_reg;
  reg  [1:0]  rxd_sync_reg;
  reg         lclk_prev_reg;
  reg  [5:0]  mode_reg;
  reg  [15:0] bd_len_reg;
  reg  [15:0] max_rx_len_reg;
  reg  [3:0]  irq_status_reg;
  reg  [3:0]  irq_mask_reg;
  reg  [31:0] tx_state_reg;
  reg  [31:0] rx_state_reg;
  reg  [31:0] zd_state_reg;
  reg  [31:0] tx_ptr_reg;
  reg  [31:0] rx_ptr_reg;
  reg  [15:0] tx_count_reg;
  reg  [15:0] rx_count_reg;
  reg  [7:0]  tx_data_reg;
  reg  [7:0]  rx_data_reg;
  reg  [7:0]  tx_shift_reg;
  reg  [7:0]  rx_shift_reg;
  reg  [2:0]  tx_bit_cnt_reg;
  reg  [2:0]  rx_bit_cnt_reg;
  reg         tx_stopped_reg;
  wire [3:0]  events;
  wire        tx_on;
  wire        tx_go;
  wire        link_edge;
  wire        active;
  wire        hdlc;
  wire        chan_hit;
  wire [7:0]  off;

  // Decodes an address into area hit and offset within the area
  function is_chan;
    input [7:0] a;
    begin
      is_chan = (a >= `MHC_CHAN_BASE);
    end
  endfunction

  assign chan_hit = is_chan(addr_in);
  assign off      = chan_hit ? addr_in - `MHC_CHAN_BASE : addr_in;
  assign hdlc     = mode_reg[`MHC_MODE_HDLC];
  // Only runs with controller started and link clock edges seen
  assign link_edge = lclk_sync_reg[1] & ~lclk_prev_reg;
  assign active    = mode_reg[`MHC_MODE_RUN] & link_edge;
  assign tx_on     = mode_reg[`MHC_MODE_RUN] & mode_reg[`MHC_MODE_ENT] &
                     mode_reg[`MHC_MODE_SLOT_VALID];
  assign tx_go     = tx_on & link_edge;
  assign irq_out   = |(irq_status_reg & irq_mask_reg);

  // Events of this cycle; the sticky status merges them below
  assign events[`MHC_EV_TX_DONE]    = tx_go && tx_bit_cnt_reg == 3'h7 &&
                                      tx_state_reg[`MHC_ST_BD_OPEN] &&
                                      !tx_stopped_reg &&
                                      tx_count_reg == 16'h0001;
  assign events[`MHC_EV_RX_FULL]    = active &&
                                      !rx_state_reg[`MHC_ST_HALTED] &&
                                      rx_bit_cnt_reg == 3'h7 &&
                                      rx_state_reg[`MHC_ST_BD_OPEN] &&
                                      rx_count_reg <= 16'h0001;
  assign events[`MHC_EV_TX_STOPPED] = wr_in && !chan_hit &&
                                      off == `MHC_OFF_COMMAND &&
                                      wdata_in[`MHC_CMD_TX_STOP];
  assign events[`MHC_EV_RX_STOPPED] = wr_in && !chan_hit &&
                                      off == `MHC_OFF_COMMAND &&
                                      wdata_in[`MHC_CMD_RX_STOP];

  //////////////////////////////////////////////////////////////////////////
  // Link input synchronisers
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      lclk_sync_reg <= 2'h0;
      rxd_sync_reg  <= 2'h0;
      lclk_prev_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      lclk_sync_reg <= {lclk_sync_reg[0], link_clk_in};
      rxd_sync_reg  <= {rxd_sync_reg[0], rx_bit_in};
      lclk_prev_reg <= lclk_sync_reg[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register writes, channel engines and events
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mode_reg       <= 6'h00;
      bd_len_reg     <= 16'h0000;
      max_rx_len_reg <= 16'h0000;
      irq_status_reg <= 4'h0;
      irq_mask_reg   <= 4'h0;
      tx_state_reg   <= `MHC_RST_TX_STATE;
      rx_state_reg   <= `MHC_RST_RX_STATE;
      zd_state_reg   <= 32'h00000000;
      tx_ptr_reg     <= 32'h00000000;
      rx_ptr_reg     <= 32'h00000000;
      tx_count_reg   <= 16'h0000;
      rx_count_reg   <= 16'h0000;
      tx_data_reg    <= 8'h00;
      rx_data_reg    <= 8'h00;
      tx_shift_reg   <= 8'hff;
      rx_shift_reg   <= 8'h00;
      tx_bit_cnt_reg <= 3'h0;
      rx_bit_cnt_reg <= 3'h0;
      tx_stopped_reg <= 1'b0;
      tx_bit_out     <= 1'b1;
    end
    else if (ce_in)
    begin
      // Software writes
      if (wr_in)
      begin
        if (!chan_hit && off == `MHC_OFF_MODE)
        begin
          mode_reg <= wdata_in[5:0];
          if (wdata_in[`MHC_MODE_POLL])
            tx_stopped_reg <= 1'b0;
        end
        else if (!chan_hit && off == `MHC_OFF_COMMAND)
        begin
          if (wdata_in[`MHC_CMD_TX_STOP])
          begin
            tx_stopped_reg <= 1'b1;
          end
          if (wdata_in[`MHC_CMD_RX_STOP])
          begin
            rx_state_reg[`MHC_ST_HALTED] <= 1'b1;
          end
        end
        else if (!chan_hit && off == `MHC_OFF_BD_LEN)
          bd_len_reg <= wdata_in[15:0];
        else if (!chan_hit && off == `MHC_OFF_MAX_RX_LEN)
          max_rx_len_reg <= wdata_in[15:0];
        else if (!chan_hit && off == `MHC_OFF_IRQ_MASK)
          irq_mask_reg <= wdata_in[3:0];
        else if (!chan_hit && off == `MHC_OFF_TX_DATA)
          tx_data_reg <= wdata_in[7:0];
        else if (chan_hit && off == `MHC_OFF_TX_STATE)
          tx_state_reg <= wdata_in;
        else if (chan_hit && off == `MHC_OFF_RX_STATE)
          rx_state_reg <= wdata_in;
        else if (chan_hit && off == `MHC_OFF_ZD_STATE)
          zd_state_reg <= wdata_in;
      end
      // Transmit engine, one bit per rising link clock edge
      if (tx_go)
      begin
        tx_state_reg[`MHC_ST_RUNNING] <= 1'b1;
        tx_bit_out   <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
        tx_bit_cnt_reg <= tx_bit_cnt_reg + 3'h1;
        if (tx_bit_cnt_reg == 3'h7)
        begin
          if (!tx_state_reg[`MHC_ST_BD_OPEN] && !tx_stopped_reg &&
              mode_reg[`MHC_MODE_POLL] && bd_len_reg != 16'h0000)
          begin
            tx_count_reg <= bd_len_reg;
            tx_state_reg[`MHC_ST_BD_OPEN] <= 1'b1;
            tx_state_reg[`MHC_ST_FRAME]   <= hdlc;
            tx_shift_reg <= `MHC_FLAG_BYTE;
          end
          else if (tx_state_reg[`MHC_ST_BD_OPEN] && !tx_stopped_reg)
          begin
            tx_shift_reg <= tx_data_reg;
            tx_ptr_reg   <= tx_ptr_reg + 32'h1;
            tx_count_reg <= tx_count_reg - 16'h1;
            if (tx_count_reg == 16'h0001)
            begin
              tx_state_reg[`MHC_ST_BD_OPEN] <= 1'b0;
              tx_state_reg[`MHC_ST_FRAME]   <= 1'b0;
            end
          end
          else
            tx_shift_reg <= mode_reg[`MHC_MODE_IDLE_FLAG] ?
                            `MHC_FLAG_BYTE : `MHC_IDLE_BYTE;
        end
      end
      // Channel off or stopped controller: release the line to idle high
      else if (!tx_on)
      begin
        tx_bit_out     <= 1'b1;
        tx_shift_reg   <= `MHC_IDLE_BYTE;
        tx_bit_cnt_reg <= 3'h0;
      end
      // Receive engine
      if (active && !rx_state_reg[`MHC_ST_HALTED])
      begin
        rx_shift_reg   <= {rxd_sync_reg[1], rx_shift_reg[7:1]};
        rx_bit_cnt_reg <= rx_bit_cnt_reg + 3'h1;
        if (rx_bit_cnt_reg == 3'h7)
        begin
          if (!rx_state_reg[`MHC_ST_BD_OPEN])
          begin
            rx_count_reg <= max_rx_len_reg;
            rx_state_reg[`MHC_ST_BD_OPEN] <= 1'b1;
            rx_state_reg[`MHC_ST_FRAME]   <= hdlc;
            rx_state_reg[15:0] <= 16'h8000;
          end
          else
          begin
            rx_data_reg  <= {rxd_sync_reg[1], rx_shift_reg[7:1]};
            rx_ptr_reg   <= rx_ptr_reg + 32'h1;
            rx_count_reg <= rx_count_reg - 16'h1;
            if (rx_count_reg <= 16'h0001)
            begin
              rx_state_reg[`MHC_ST_BD_OPEN] <= 1'b0;
              rx_state_reg[`MHC_ST_FRAME]   <= 1'b0;
              rx_state_reg[15:0] <= 16'h0000;
            end
          end
        end
      end
      // Sticky status: set wins over write-one-to-clear
      if (wr_in && !chan_hit && off == `MHC_OFF_IRQ_STATUS)
        irq_status_reg <= (irq_status_reg & ~wdata_in[3:0]) | events;
      else
        irq_status_reg <= irq_status_reg | events;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= 32'h00000000;
    else if (ce_in)
    begin
      rdata_out <= 32'h00000000;
      if (rd_in)
      begin
        if (!chan_hit && off == `MHC_OFF_GLOBAL_RUN)
          rdata_out <= {31'h0, ~mode_reg[`MHC_MODE_RUN]};
        else if (!chan_hit && off == `MHC_OFF_MODE)
          rdata_out <= {26'h0, mode_reg};
        else if (!chan_hit && off == `MHC_OFF_BD_LEN)
          rdata_out <= {16'h0, bd_len_reg};
        else if (!chan_hit && off == `MHC_OFF_MAX_RX_LEN)
          rdata_out <= {16'h0, max_rx_len_reg};
        else if (!chan_hit && off == `MHC_OFF_IRQ_STATUS)
          rdata_out <= {28'h0, irq_status_reg};
        else if (!chan_hit && off == `MHC_OFF_IRQ_MASK)
          rdata_out <= {28'h0, irq_mask_reg};
        else if (!chan_hit && off == `MHC_OFF_TX_DATA)
          rdata_out <= {24'h0, tx_data_reg};
        else if (!chan_hit && off == `MHC_OFF_RX_DATA)
          rdata_out <= {24'h0, rx_data_reg};
        else if (chan_hit && off == `MHC_OFF_TX_STATE)
          rdata_out <= tx_state_reg;
        else if (chan_hit && off == `MHC_OFF_TX_PTR)
          rdata_out <= tx_ptr_reg;
        else if (chan_hit && off == `MHC_OFF_ZD_STATE)
          rdata_out <= zd_state_reg;
        else if (chan_hit && off == `MHC_OFF_TX_COUNT)
          rdata_out <= {16'h0, tx_count_reg};
        else if (chan_hit && off == `MHC_OFF_RX_STATE)
          rdata_out <= rx_state_reg;
        else if (chan_hit && off == `MHC_OFF_RX_PTR)
          rdata_out <= rx_ptr_reg;
        else if (chan_hit && off == `MHC_OFF_RX_COUNT)
          rdata_out <= {16'h0, rx_count_reg};
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/mhc_chan_ctrl_assertions.sv ----
// Port checker of the channel control block
`timescale 1ns/10ps
`default_nettype none
module mhc_chan_chk
(
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  // Register port
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  // Link and interrupt
  input wire logic        link_clk_in,
  input wire logic        rx_bit_in,
  input wire logic        tx_bit_out,
  input wire logic        irq_out
);
  logic       run_reg;
  logic       stop_reg;
  logic       flag_reg;
  logic [4:0] run_age_reg;
  logic [8:0] quiet_reg;
  wire        mode_wr = wr_in && ce_in && addr_in == 8'h10;
  wire        quiet = !run_reg || (stop_reg && !flag_reg);
  //////////////////////////////////////////////////////////////////////////
  // Track run, idle choice, stop and how long the line must be idle
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      run_reg <= 1'b0;
      stop_reg <= 1'b0;
      flag_reg <= 1'b0;
      run_age_reg <= 5'h0;
      quiet_reg <= 9'h0;
    end
    else if (ce_in)
    begin
      if (mode_wr)
      begin
        run_reg <= wdata_in[5];
        flag_reg <= wdata_in[1];
      end
      if (mode_wr && wdata_in[3])
        stop_reg <= 1'b0;
      else if (wr_in && addr_in == 8'h14 && wdata_in[0])
        stop_reg <= 1'b1;
      if (mode_wr && wdata_in[5] != run_reg)
        run_age_reg <= 5'h0;
      else if (run_age_reg != 5'h1f)
        run_age_reg <= run_age_reg + 5'h1;
      if (!quiet)
        quiet_reg <= 9'h0;
      else if (quiet_reg != 9'h1ff)
        quiet_reg <= quiet_reg + 9'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  rst_out_a: assert property (disable iff (1'b0) rst_in && ce_in |=>
    rdata_out == 32'h0 && tx_bit_out && !irq_out) else $error("reset out");
  rdata_idle_a: assert property (!rd_in && ce_in |=> rdata_out == 32'h0)
    else $error("read data without read");
  unmapped_rd_a: assert property (
    rd_in && ce_in && addr_in == 8'h30 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  freeze_out_a: assert property (
    !ce_in |=> $stable(tx_bit_out) && $stable(irq_out))
    else $error("outputs moved while frozen");
  run_flag_a: assert property (
    rd_in && ce_in && addr_in == 8'h04 && run_age_reg == 5'h1f
    |=> rdata_out[0] == !run_reg) else $error("stopped flag wrong");
  mask_off_a: assert property (
    wr_in && ce_in && addr_in == 8'h24 && wdata_in == 32'h0 |=> !irq_out)
    else $error("irq with mask cleared");
  quiet_line_a: assert property (quiet_reg == 9'h1ff |-> tx_bit_out)
    else $error("line not idle");
  count_width_a: assert property (
    rd_in && ce_in && (addr_in == 8'h4e || addr_in == 8'h6e)
    |=> rdata_out[31:16] == 16'h0) else $error("count upper half set");
  cover property (run_reg && stop_reg);
  cover property (irq_out);
  cover property (rd_in && addr_in == 8'h64);
endmodule
bind mhc_chan_ctrl mhc_chan_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .link_clk_in(link_clk_in),
  .rx_bit_in(rx_bit_in), .tx_bit_out(tx_bit_out), .irq_out(irq_out));
`default_nettype wire

// ---- tb/mhc_line_model.sv ----
// Serial line partner: link clock, receive flags, transmit capture
`timescale 1ns/10ps
`default_nettype none
module mhc_line_model
(
  // Line side
  input  wire logic        tx_bit_in,
  output var  logic        link_clk_out,
  output var  logic        rx_bit_out,
  output var  logic [15:0] bits_out
);
  localparam logic [7:0] FLAG_PAT = 8'h7e;
  logic [2:0] pos_reg = 3'h0;
  //////////////////////////////////////////////////////////////////////////
  // Free running link clock, out of phase with the system clock
  initial
  begin
    link_clk_out = 1'b0;
    #37;
    forever #100 link_clk_out = ~link_clk_out;
  end
  // Receive flags, LSB first, changed on the falling edge
  initial rx_bit_out = 1'b0;
  always @(negedge link_clk_out)
  begin
    rx_bit_out <= FLAG_PAT[pos_reg];
    pos_reg <= pos_reg + 3'h1;
  end
  // Last 16 line bits, newest in the top bit
  initial bits_out = 16'h0;
  always @(posedge link_clk_out)
    bits_out <= {tx_bit_in, bits_out[15:1]};
endmodule
`default_nettype wire

// ---- tb/tb_mhc_chan_ctrl.sv ----
// Testbench of the channel control block
`timescale 1ns/10ps
`default_nettype none
module tb_mhc_chan_ctrl;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ce_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  wire  [31:0] rdata_out;
  wire         link_clk;
  wire         rx_bit;
  wire         tx_bit_out;
  wire         irq_out;
  wire  [15:0] bits;
  logic [31:0] v;
  int          err_total = 0;
  int          check_count = 0;
  //////////////////////////////////////////////////////////////////////////
  // Clock, design and line partner
  always #12.5 clk_in = ~clk_in;
  mhc_chan_ctrl u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .link_clk_in(link_clk), .rx_bit_in(rx_bit),
    .tx_bit_out(tx_bit_out), .irq_out(irq_out));
  mhc_line_model u_line (.tx_bit_in(tx_bit_out), .link_clk_out(link_clk),
    .rx_bit_out(rx_bit), .bits_out(bits));
  //////////////////////////////////////////////////////////////////////////
  // Register access, comparison and closing tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 4000 && irq_out !== 1'b1; n++)
      @(posedge clk_in);
    chk("irq raised", irq_out, 1'b1);
    if (irq_out !== 1'b1)
      end_sim();
  endtask
  function automatic logic has_flag(input logic [15:0] b);
    for (int i = 0; i < 9; i++)
      if (b[i+:8] == 8'h7e)
        return 1'b1;
    return 1'b0;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge clk_in);
    err_total++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (200) @(posedge clk_in);
    rd(8'h04, v); chk("stopped flag", v[0], 1'b1);
    rd(8'h44, v); chk("tx state", v, 32'h38000000);
    rd(8'h64, v); chk("rx state", v, 32'h39000000);
    wr(8'h30, 32'hffffffff);
    rd(8'h30, v); chk("unmapped", v, 32'h0);
    chk("irq idle", irq_out, 1'b0);
    @(posedge clk_in);
    ce_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    ce_in <= 1'b1;
    $display("test reset done");
    wr(8'h64, 32'h39000000);
    wr(8'h4c, 32'h00000080);
    wr(8'h44, 32'h38000000);
    wr(8'h18, 32'h3);
    wr(8'h1c, 32'h8);
    wr(8'h24, 32'hc);
    wr(8'h28, 32'ha5);
    wr(8'h10, 32'h35);
    wr(8'h10, 32'h3d);
    repeat (400) @(posedge clk_in);
    rd(8'h04, v); chk("stopped flag", v[0], 1'b0);
    rd(8'h44, v); chk("tx running", v[12], 1'b1);
    rd(8'h4e, v); chk("tx count", v <= 32'h3, 1'b1);
    rd(8'h6e, v); chk("rx count", v <= 32'h8, 1'b1);
    $display("test start done");
    wr(8'h14, 32'h1);
    wait_irq();
    repeat (800) @(posedge clk_in);
    chk("idle line", bits, 16'hffff);
    wr(8'h20, 32'hf);
    chk("irq cleared", irq_out, 1'b0);
    wr(8'h14, 32'h2);
    wait_irq();
    rd(8'h64, v); chk("rx halted", v[11], 1'b1);
    wr(8'h64, 32'h39000000);
    wr(8'h4c, 32'h00000080);
    rd(8'h64, v); chk("rx resumed", v[11], 1'b0);
    wr(8'h24, 32'h0);
    chk("irq masked", irq_out, 1'b0);
    $display("test stop done");
    wr(8'h10, 32'h37);
    repeat (800) @(posedge clk_in);
    chk("flag line", has_flag(bits), 1'b1);
    wr(8'h10, 32'h3c);
    repeat (400) @(posedge clk_in);
    rd(8'h44, v); chk("no frame bit", v[8], 1'b0);
    wr(8'h10, 32'h20);
    repeat (800) @(posedge clk_in);
    chk("off line", bits, 16'hffff);
    wr(8'h10, 32'h0);
    repeat (40) @(posedge clk_in);
    rd(8'h04, v); chk("stopped flag", v[0], 1'b1);
    $display("test deactivate done");
    end_sim();
  end
endmodule
`default_nettype wire
